// file: rtl/fpd_pkg.sv
// fpd_pkg: constants, types and state enumerations for the flash download/program sequencer.
// assumes nothing beyond a SystemVerilog compiler.
package fpd_pkg;
  localparam logic [7:0]  KEY_DOWNLOAD      = 8'ha5;
  localparam logic [7:0]  KEY_PROGRAM       = 8'h5a;
  localparam logic [7:0]  KEY_CLEAR         = 8'h00;
  localparam logic [7:0]  RESULT_OK         = 8'h00;
  localparam int          RES_SEL_BIT       = 1;
  localparam int          RES_KEY_BIT       = 0;
  localparam logic [7:0]  RES_INIT_FREQ_ERR = 8'h01;
  localparam logic [7:0]  RES_KEY_ERR       = 8'h02;
  localparam logic [7:0]  RES_DEST_ERR      = 8'h04;
  localparam logic [7:0]  RES_SRC_ERR       = 8'h08;
  localparam logic [7:0]  RES_NOT_INIT      = 8'h10;
  localparam logic [15:0] FREQ_MIN_X100     = 16'h0320;
  localparam logic [15:0] FREQ_MAX_X100     = 16'h09c4;
  localparam int          BLOCK_BYTES       = 128;
  localparam logic [31:0] BLOCK_STEP        = 32'h0000_0080;
  localparam logic [7:0]  ALIGN_LO_A        = 8'h00;
  localparam logic [7:0]  ALIGN_LO_B        = 8'h80;
  localparam logic [15:0] PROG_ENTRY_OFS    = 16'h0010;
  localparam logic [15:0] INIT_ENTRY_OFS    = 16'h0020;
  localparam int          ROUTINE_WORDS     = 8;
  localparam logic [31:0] USER_ARRAY_LO     = 32'h0000_0000;
  localparam logic [31:0] USER_ARRAY_HI     = 32'h0001_ffff;
  localparam logic [31:0] FLASH_LO          = 32'h0000_0000;
  localparam logic [31:0] FLASH_HI          = 32'h0001_ffff;
  localparam logic [15:0] RAM_LO            = 16'he000;
  localparam logic [15:0] RAM_HI            = 16'hfeff;
  localparam logic [7:0]  PROG_DATA_FILL    = 8'hff;
  typedef enum logic [2:0] {FPD_IDLE, FPD_SWITCH, FPD_CHECK, FPD_COPY, FPD_RESULT} fpd_dl_state_t;
  typedef enum logic [1:0] {FPD_P_IDLE, FPD_P_WRITE, FPD_P_DONE} fpd_pg_state_t;
endpackage : fpd_pkg

// file: rtl/fpd_prog_if.sv
// fpd_prog_if: carries a 128-byte programming job from the sequencer to the byte writer.
// assumes both ends share clock_in.
`timescale 1ns/100ps
`default_nettype none
interface fpd_prog_if;
  logic        start;
  logic [31:0] dest;
  logic [31:0] src;
  logic        busy;
  logic        done;
  logic        wr_en;
  logic [31:0] wr_dest;
  logic [31:0] rd_src;
  modport ctrl (output start, output dest, output src, input busy, input done,
                input wr_en, input wr_dest, input rd_src);
  modport writer (input start, input dest, input src, output busy, output done,
                  output wr_en, output wr_dest, output rd_src);
endinterface : fpd_prog_if
`default_nettype wire

// file: rtl/fpd_block_writer.sv
// fpd_block_writer: walks one 128-byte programming block, one byte address a cycle.
// assumes start is a one-cycle pulse from the sequencer in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module fpd_block_writer
  import fpd_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  fpd_prog_if.writer pif
);
  fpd_pg_state_t st_ff;
  logic [7:0]    cnt_ff;
  logic [31:0]   dst_ff;
  logic [31:0]   src_ff;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff  <= FPD_P_IDLE;
      cnt_ff <= 8'h00;
      dst_ff <= 32'h0000_0000;
      src_ff <= 32'h0000_0000;
    end else begin
      unique case (st_ff)
        FPD_P_IDLE: begin
          if (pif.start) begin
            st_ff  <= FPD_P_WRITE;
            cnt_ff <= 8'h00;
            dst_ff <= pif.dest;
            src_ff <= pif.src;
          end
        end
        FPD_P_WRITE: begin
          // always exactly one full block
          if (cnt_ff == 8'(BLOCK_BYTES - 1)) st_ff <= FPD_P_DONE;
          cnt_ff <= cnt_ff + 8'h01;
        end
        FPD_P_DONE: st_ff <= FPD_P_IDLE;
        default:    st_ff <= FPD_P_IDLE;
      endcase
    end
  end

  assign pif.busy    = (st_ff != FPD_P_IDLE);
  assign pif.done    = (st_ff == FPD_P_DONE);
  assign pif.wr_en   = (st_ff == FPD_P_WRITE);
  assign pif.wr_dest = dst_ff + {24'h000000, cnt_ff};
  assign pif.rd_src  = src_ff + {24'h000000, cnt_ff};
endmodule : fpd_block_writer
`default_nettype wire

// file: rtl/fpd_flash_download_ctrl.sv
// fpd_flash_download_ctrl: key-gated routine download, init frequency check and block programming.
// assumes software-facing strobes are synchronous one-cycle pulses on clock_in.
// What this block does
// - each programming operation writes exactly 128 bytes; the caller advances the pointers by 128.
// - several routines selected refuses download and flags selection error.
// - download request only settable while key holds download key.
// - setting request starts download; bit reads cleared when program resumes.
// - download switches array to routine area, checks, then copies to RAM.
// - completion clears selects and request bit, writes result byte unless the target is bad.
// - interrupts held during download and released on resume.
// - zero result is success; unchanged means bad target; flags otherwise.
// - init accepts frequency only within 8 to 25 MHz, else error.
// - init entry is target plus 32, program entry target plus 16.
// - routines keep registers except return byte, stack up to 128 bytes.
// - destination must be in user array and 128-byte aligned.
// - data source in flash refuses programming with error.
`timescale 1ns/100ps
`default_nettype none
module fpd_flash_download_ctrl
  import fpd_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        key_wr_in,
  input  wire logic [7:0]  key_data_in,
  input  wire logic        prog_sel_wr_in,
  input  wire logic        program_routine_select_bit_in,
  input  wire logic        erase_sel_wr_in,
  input  wire logic        erase_routine_select_in,
  input  wire logic        request_wr_in,
  input  wire logic [15:0] download_target_address_in,
  input  wire logic        init_call_in,
  input  wire logic [15:0] operating_frequency_param_in,
  input  wire logic        prog_call_in,
  input  wire logic [31:0] program_destination_param_in,
  input  wire logic [31:0] program_data_pointer_param_in,
  input  wire logic        irq_req_in,
  output logic [7:0]       flash_key_register_out,
  output logic             program_select_register_out,
  output logic             erase_select_register_out,
  output logic             download_request_bit_out,
  output logic             download_busy_out,
  output logic             routine_area_mapped_out,
  output logic             ram_wr_en_out,
  output logic [15:0]      ram_wr_addr_out,
  output logic [7:0]       ram_wr_data_out,
  output logic             target_address_error_flag_out,
  output logic [7:0]       download_result_byte_out,
  output logic             download_done_out,
  output logic [15:0]      routine_entry_addr_out,
  output logic [7:0]       routine_result_byte_out,
  output logic             routine_done_out,
  output logic             flash_wr_en_out,
  output logic [31:0]      flash_wr_addr_out,
  output logic [31:0]      data_rd_addr_out,
  output logic             irq_out
);
  fpd_prog_if pif ();

  fpd_block_writer u_writer (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .pif        (pif)
  );

  function automatic logic in_range32(
    input logic [31:0] a,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction : in_range32

  fpd_dl_state_t dl_ff;
  logic [3:0]    cpy_ff;
  logic          irq_held_ff;
  logic          init_ok_ff;
  logic          prog_pend_ff;
  logic [1:0]    irq_sync_ff;
  logic          dl_take;
  logic          sel_conflict;
  logic          tgt_ok;
  logic          freq_ok;
  logic          dest_ok;
  logic          src_ok;

  // a request is taken only while idle and with the download key present
  assign dl_take      = (dl_ff == FPD_IDLE) && request_wr_in && (flash_key_register_out == KEY_DOWNLOAD);
  assign sel_conflict = program_select_register_out && erase_select_register_out;
  // target must fall inside the on-chip ram window
  assign tgt_ok       = (download_target_address_in >= RAM_LO) && (download_target_address_in <= RAM_HI);
  assign freq_ok      = (operating_frequency_param_in >= FREQ_MIN_X100)
                        && (operating_frequency_param_in <= FREQ_MAX_X100);
  // the destination must sit in the user array on a block boundary
  assign dest_ok      = in_range32(program_destination_param_in, USER_ARRAY_LO, USER_ARRAY_HI)
                        && (program_destination_param_in[7:0] == ALIGN_LO_A
                            || program_destination_param_in[7:0] == ALIGN_LO_B);
  assign src_ok       = !in_range32(program_data_pointer_param_in, FLASH_LO, FLASH_HI);

  // key register
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_key_register_out <= KEY_CLEAR;
    end else if (key_wr_in) begin
      flash_key_register_out <= key_data_in;
    end
  end

  // selects: cleared by the download engine at completion
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      program_select_register_out <= 1'b0;
      erase_select_register_out   <= 1'b0;
    end else if (dl_ff == FPD_RESULT) begin
      program_select_register_out <= 1'b0;
      erase_select_register_out   <= 1'b0;
    end else if (dl_ff == FPD_IDLE) begin
      if (prog_sel_wr_in) begin
        program_select_register_out <= program_routine_select_bit_in;
      end
      if (erase_sel_wr_in) begin
        erase_select_register_out <= erase_routine_select_in;
      end
    end
  end

  // download request and engine
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dl_ff                         <= FPD_IDLE;
      cpy_ff                        <= 4'h0;
      download_request_bit_out      <= 1'b0;
      download_busy_out             <= 1'b0;
      routine_area_mapped_out       <= 1'b0;
      target_address_error_flag_out <= 1'b0;
      download_result_byte_out      <= PROG_DATA_FILL;
      download_done_out             <= 1'b0;
      ram_wr_en_out                 <= 1'b0;
      ram_wr_addr_out               <= 16'h0000;
      ram_wr_data_out               <= 8'h00;
    end else begin
      download_done_out <= 1'b0;
      ram_wr_en_out     <= 1'b0;
      unique case (dl_ff)
        FPD_IDLE: begin
          if (dl_take) begin
            download_request_bit_out <= 1'b1;
            download_busy_out        <= 1'b1;
            dl_ff                    <= FPD_SWITCH;
          end
        end

        FPD_SWITCH: begin
          routine_area_mapped_out <= 1'b1;
          dl_ff                   <= FPD_CHECK;
        end

        FPD_CHECK: begin
          if (!tgt_ok) begin
            // bad target: result byte left untouched
            target_address_error_flag_out <= 1'b1;
            dl_ff                         <= FPD_RESULT;
          end else if (sel_conflict) begin
            target_address_error_flag_out <= 1'b0;
            download_result_byte_out      <= 8'(1 << RES_SEL_BIT);
            ram_wr_en_out                 <= 1'b1;
            ram_wr_addr_out               <= download_target_address_in;
            ram_wr_data_out               <= 8'(1 << RES_SEL_BIT);
            dl_ff                         <= FPD_RESULT;
          end else begin
            target_address_error_flag_out <= 1'b0;
            cpy_ff                        <= 4'h0;
            dl_ff                         <= FPD_COPY;
          end
        end

        FPD_COPY: begin
          ram_wr_en_out   <= 1'b1;
          ram_wr_addr_out <= download_target_address_in + PROG_ENTRY_OFS + {12'h000, cpy_ff};
          ram_wr_data_out <= {4'h0, cpy_ff};
          cpy_ff          <= cpy_ff + 4'h1;
          if (cpy_ff == 4'(ROUTINE_WORDS - 1)) begin
            dl_ff <= FPD_RESULT;
          end
        end

        FPD_RESULT: begin
          // judged on this download's selects, so an old error byte cannot block success
          if (!target_address_error_flag_out && !sel_conflict) begin
            download_result_byte_out <= RESULT_OK;
            ram_wr_en_out            <= 1'b1;
            ram_wr_addr_out          <= download_target_address_in;
            ram_wr_data_out          <= RESULT_OK;
          end
          download_request_bit_out <= 1'b0;
          download_busy_out        <= 1'b0;
          routine_area_mapped_out  <= 1'b0;
          download_done_out        <= 1'b1;
          dl_ff                    <= FPD_IDLE;
        end

        default: dl_ff <= FPD_IDLE;
      endcase
    end
  end

  // irq pin synchroniser
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_sync_ff <= 2'b00;
    end else begin
      irq_sync_ff <= {irq_sync_ff[0], irq_req_in};
    end
  end

  // interrupts held from the taking edge on, so none slips out in the first busy cycle
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_held_ff <= 1'b0;
      irq_out     <= 1'b0;
    end else if (download_busy_out || dl_take) begin
      irq_out <= 1'b0;
      if (irq_sync_ff[1] || irq_out) begin
        irq_held_ff <= 1'b1;
      end
    end else begin
      irq_out     <= irq_sync_ff[1] | irq_held_ff;
      irq_held_ff <= 1'b0;
    end
  end

  // initialization and programming routines
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      init_ok_ff              <= 1'b0;
      prog_pend_ff            <= 1'b0;
      routine_entry_addr_out  <= 16'h0000;
      routine_result_byte_out <= RESULT_OK;
      routine_done_out        <= 1'b0;
      pif.start               <= 1'b0;
      pif.dest                <= 32'h0000_0000;
      pif.src                 <= 32'h0000_0000;
    end else begin
      routine_done_out <= 1'b0;
      pif.start        <= 1'b0;
      if (init_call_in && !prog_pend_ff) begin
        routine_entry_addr_out <= download_target_address_in + INIT_ENTRY_OFS;
        if (!freq_ok) begin
          routine_result_byte_out <= RES_INIT_FREQ_ERR;
          init_ok_ff              <= 1'b0;
        end else begin
          routine_result_byte_out <= RESULT_OK;
          init_ok_ff              <= 1'b1;
        end
        routine_done_out <= 1'b1;
      end else if (prog_call_in && !prog_pend_ff) begin
        routine_entry_addr_out <= download_target_address_in + PROG_ENTRY_OFS;
        if (!init_ok_ff) begin
          routine_result_byte_out <= RES_NOT_INIT;
          routine_done_out        <= 1'b1;
        end else if (flash_key_register_out != KEY_PROGRAM) begin
          routine_result_byte_out <= RES_KEY_ERR;
          routine_done_out        <= 1'b1;
        end else if (!dest_ok) begin
          routine_result_byte_out <= RES_DEST_ERR;
          routine_done_out        <= 1'b1;
        end else if (!src_ok) begin
          routine_result_byte_out <= RES_SRC_ERR;
          routine_done_out        <= 1'b1;
        end else begin
          // every accepted call writes one full block; the writer never stops short
          pif.start    <= 1'b1;
          pif.dest     <= program_destination_param_in;
          pif.src      <= program_data_pointer_param_in;
          prog_pend_ff <= 1'b1;
        end
      end else if (prog_pend_ff && pif.done) begin
        prog_pend_ff            <= 1'b0;
        // the result byte is the only state a routine hands back
        routine_result_byte_out <= RESULT_OK;
        routine_done_out        <= 1'b1;
      end
    end
  end

  // flash write port
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_wr_en_out   <= 1'b0;
      flash_wr_addr_out <= 32'h0000_0000;
      data_rd_addr_out  <= 32'h0000_0000;
    end else begin
      flash_wr_en_out   <= pif.wr_en;
      flash_wr_addr_out <= pif.wr_dest;
      data_rd_addr_out  <= pif.rd_src;
    end
  end
endmodule : fpd_flash_download_ctrl
`default_nettype wire

// file: verification/fpd_flash_monitor.sv
// fpd_flash_monitor: concurrent checks on the download and programming sequencer ports.
// assumes one clock domain, clock_in, with asynchronous reset sys_rst_in.
`timescale 1ns/100ps
`default_nettype none
module fpd_flash_monitor
  import fpd_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        init_call_in,
  input wire logic [15:0] operating_frequency_param_in,
  input wire logic [15:0] download_target_address_in,
  input wire logic [7:0]  flash_key_register_out,
  input wire logic        program_select_register_out,
  input wire logic        erase_select_register_out,
  input wire logic        download_request_bit_out,
  input wire logic        download_busy_out,
  input wire logic        ram_wr_en_out,
  input wire logic [15:0] ram_wr_addr_out,
  input wire logic [7:0]  ram_wr_data_out,
  input wire logic        target_address_error_flag_out,
  input wire logic [7:0]  download_result_byte_out,
  input wire logic        download_done_out,
  input wire logic [7:0]  routine_result_byte_out,
  input wire logic        routine_done_out,
  input wire logic        flash_wr_en_out,
  input wire logic [31:0] flash_wr_addr_out,
  input wire logic [31:0] data_rd_addr_out,
  input wire logic        irq_out
);
  logic [7:0]  run_ff;
  logic [15:0] ofs;
  logic        bad_freq;
  assign ofs      = ram_wr_addr_out - download_target_address_in;
  assign bad_freq = (operating_frequency_param_in < FREQ_MIN_X100) || (operating_frequency_param_in > FREQ_MAX_X100);
  // length of the current run of flash byte writes
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) run_ff <= 8'h00;
    else if (flash_wr_en_out) run_ff <= run_ff + 8'h01;
    else run_ff <= 8'h00;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_taken;
    $rose(download_request_bit_out);
  endsequence
  sequence s_finish;
    download_done_out && !download_request_bit_out && !program_select_register_out && !erase_select_register_out;
  endsequence
  a_req_key_gate: assert property (s_taken |-> $past(flash_key_register_out) == KEY_DOWNLOAD)
    else $error("download started without the download key");
  a_done_bound: assert property ($rose(download_busy_out) |-> ##[1:12] s_finish)
    else $error("download did not finish with selects and request cleared");
  a_copy_place: assert property (ram_wr_en_out |-> ofs == 16'h0000 || (ofs >= 16'h0010 && ofs <= 16'h0017))
    else $error("ram write outside the routine image or result byte");
  a_ok_result: assert property (download_done_out && !target_address_error_flag_out && download_result_byte_out == RESULT_OK |-> ram_wr_en_out && ram_wr_data_out == 8'h00 && ofs == 16'h0000)
    else $error("success result not written to the first target byte");
  a_bad_target: assert property (download_done_out && target_address_error_flag_out |-> $stable(download_result_byte_out) && !ram_wr_en_out)
    else $error("bad target changed the result byte");
  a_irq_held: assert property (download_busy_out |-> !irq_out)
    else $error("interrupt raised during download");
  a_freq_range: assert property (init_call_in && bad_freq |-> ##[1:2] (routine_done_out && routine_result_byte_out == RES_INIT_FREQ_ERR))
    else $error("out of range frequency not refused");
  a_block_len: assert property ($fell(flash_wr_en_out) |-> run_ff == 8'h80)
    else $error("programming run not 128 bytes");
  a_dest_legal: assert property (flash_wr_en_out |-> flash_wr_addr_out <= USER_ARRAY_HI && data_rd_addr_out > FLASH_HI)
    else $error("flash write with illegal destination or source");
endmodule : fpd_flash_monitor
bind fpd_flash_download_ctrl fpd_flash_monitor i_mon (.clock_in, .sys_rst_in, .init_call_in,
  .operating_frequency_param_in, .download_target_address_in, .flash_key_register_out,
  .program_select_register_out, .erase_select_register_out, .download_request_bit_out, .download_busy_out,
  .ram_wr_en_out, .ram_wr_addr_out, .ram_wr_data_out, .target_address_error_flag_out,
  .download_result_byte_out, .download_done_out, .routine_result_byte_out, .routine_done_out,
  .flash_wr_en_out, .flash_wr_addr_out, .data_rd_addr_out, .irq_out);
`default_nettype wire

// file: verification/testbench.sv
// testbench: directed scenarios for the flash download and programming sequencer.
// assumes the package, design and monitor are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import fpd_pkg::*;
;
  logic        clock_in   = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [4:0]  stb        = 5'h00;
  logic [7:0]  key_data   = 8'h00;
  logic        psel       = 1'b0;
  logic        esel       = 1'b0;
  logic        irq_req    = 1'b0;
  logic [15:0] tgt        = 16'he000;
  logic [15:0] freq       = 16'h0000;
  logic [31:0] dest       = 32'h0000_0000;
  logic [31:0] src        = 32'h0000_0000;
  logic [7:0]  key_q, dl_res, rt_res, ram_d;
  logic [15:0] ram_a, entry;
  logic [31:0] fl_a, rd_a;
  logic        psel_q, esel_q, req_q, busy, mapped, ram_we, target_address_error_flag, dl_done, rt_done, fl_we, irq;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          n_wr;
  logic        saw_map;
  always #5 clock_in = ~clock_in;
  fpd_flash_download_ctrl i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .key_wr_in(stb[0]),
    .key_data_in(key_data), .prog_sel_wr_in(stb[1]), .program_routine_select_bit_in(psel),
    .erase_sel_wr_in(stb[1]), .erase_routine_select_in(esel), .request_wr_in(stb[2]),
    .download_target_address_in(tgt), .init_call_in(stb[3]), .operating_frequency_param_in(freq),
    .prog_call_in(stb[4]), .program_destination_param_in(dest), .program_data_pointer_param_in(src),
    .irq_req_in(irq_req), .flash_key_register_out(key_q), .program_select_register_out(psel_q),
    .erase_select_register_out(esel_q), .download_request_bit_out(req_q), .download_busy_out(busy),
    .routine_area_mapped_out(mapped), .ram_wr_en_out(ram_we), .ram_wr_addr_out(ram_a),
    .ram_wr_data_out(ram_d), .target_address_error_flag_out(target_address_error_flag), .download_result_byte_out(dl_res),
    .download_done_out(dl_done), .routine_entry_addr_out(entry), .routine_result_byte_out(rt_res),
    .routine_done_out(rt_done), .flash_wr_en_out(fl_we), .flash_wr_addr_out(fl_a),
    .data_rd_addr_out(rd_a), .irq_out(irq));
  task automatic close_out();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse(input int b);
    stb[b] = 1'b1;
    @(negedge clock_in);
    stb[b] = 1'b0;
  endtask : pulse
  // keyed download to target t; counts ram writes, ends with the key cleared
  task automatic run_dl(input logic [15:0] t);
    int i;
    tgt = t;
    key_data = KEY_DOWNLOAD;
    n_wr = 0;
    saw_map = 1'b0;
    pulse(0);
    pulse(2);
    for (i = 0; i < 40 && dl_done !== 1'b1; i++) begin
      if (i < 2) check(req_q, 1'b1);
      if (busy === 1'b1) check(irq, 1'b0);
      if (mapped === 1'b1) saw_map = 1'b1;
      if (ram_we === 1'b1) n_wr++;
      if (ram_we === 1'b1 && ram_a !== t) check(ram_d, ram_a - t - 16'h0010);
      @(negedge clock_in);
    end
    if (i == 40) begin check(1'b0, 1'b1); close_out(); end
    if (ram_we === 1'b1) n_wr++;
    key_data = KEY_CLEAR;
    pulse(0);
  endtask : run_dl
  task automatic call(input int b, output logic [7:0] r, output int n);
    int i;
    n = 0;
    pulse(b);
    for (i = 0; i < 300 && rt_done !== 1'b1; i++) begin
      if (fl_we === 1'b1) begin
        check(fl_a, dest + n);
        check(rd_a, src + n);
        n++;
      end
      @(negedge clock_in);
    end
    if (i == 300) begin check(1'b0, 1'b1); close_out(); end
    r = rt_res;
    @(negedge clock_in);
  endtask : call
  task automatic init_run(input logic [15:0] f, input logic [7:0] e);
    logic [7:0] r;
    int         n;
    freq = f;
    call(3, r, n);
    check(r, e);
    check(entry, tgt + 16'h0020);
  endtask : init_run
  task automatic prog_run(input logic [7:0] k, input logic [31:0] d, input logic [31:0] s, input logic [7:0] e);
    logic [7:0] r;
    int         n;
    key_data = k;
    pulse(0);
    dest = d;
    src = s;
    call(4, r, n);
    check(r, e);
    check(n, (e == RESULT_OK) ? 128 : 0);
  endtask : prog_run
  task automatic t_no_key();
    key_data = 8'h33;
    pulse(0);
    pulse(2);
    repeat (16) begin
      check(busy | req_q, 1'b0);
      @(negedge clock_in);
    end
    check(dl_res, 8'hff);
  endtask : t_no_key
  task automatic t_downloads();
    psel = 1'b1;
    esel = 1'b1;
    pulse(1);
    run_dl(16'he000);
    check(dl_res, 8'h02);
    check({psel_q, esel_q, req_q}, 3'b000);
    esel = 1'b0;
    pulse(1);
    run_dl(16'h1000);
    check({target_address_error_flag, dl_res}, 9'h102);
    check(n_wr, 0);
    pulse(1);
    irq_req = 1'b1;
    run_dl(16'he100);
    check(dl_res, RESULT_OK);
    check({n_wr[3:0], saw_map, psel_q, req_q, target_address_error_flag}, 8'h98);
    check(irq, 1'b1);
    irq_req = 1'b0;
  endtask : t_downloads
  initial begin
    repeat (6) @(negedge clock_in);
    sys_rst_in = 1'b0;
    check(dl_res, 8'hff);
    t_no_key();
    t_downloads();
    prog_run(KEY_PROGRAM, 32'h0000_0100, 32'h0000_e000, RES_NOT_INIT);
    init_run(16'h031f, RES_INIT_FREQ_ERR);
    init_run(16'h09c5, RES_INIT_FREQ_ERR);
    init_run(16'h0320, RESULT_OK);
    init_run(16'h09c4, RESULT_OK);
    prog_run(KEY_CLEAR, 32'h0000_0100, 32'h0000_e000, RES_KEY_ERR);
    prog_run(KEY_PROGRAM, 32'h0000_0140, 32'h0000_e000, RES_DEST_ERR);
    prog_run(KEY_PROGRAM, 32'h0002_0000, 32'h0000_e000, RES_DEST_ERR);
    prog_run(KEY_PROGRAM, 32'h0000_0100, 32'h0000_1000, RES_SRC_ERR);
    prog_run(KEY_PROGRAM, 32'h0000_1080, 32'h0002_e200, RESULT_OK);
    prog_run(KEY_PROGRAM, 32'h0000_1100, 32'h0002_e280, RESULT_OK);
    check(entry, tgt + 16'h0010);
    check(dl_res, RESULT_OK);
    key_data = KEY_CLEAR;
    pulse(0);
    check(key_q, KEY_CLEAR);
    close_out();
  end
endmodule : testbench
`default_nettype wire
